// [design/sfrpg_pkg.sv]
package sfrpg_pkg;

  // --------------------------------------------------------------------
  // Register space addresses
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_ACTIVE_PAGE = 8'hA7;
  localparam logic [7:0] ADDR_PAGE_CTRL = 8'hCF;
  localparam logic [7:0] ADDR_STACK_VIEW = 8'hD3;

  // --------------------------------------------------------------------
  // Page codes
  // --------------------------------------------------------------------
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] PAGE_F = 8'h0F;

  // --------------------------------------------------------------------
  // Page control fields and reset values
  // --------------------------------------------------------------------
  localparam int IDX_LSB = 4;
  localparam int IDX_MSB = 6;
  localparam int AUTO_EN_BIT = 0;
  localparam logic [2:0] IDX_LAST_LEVEL = 3'h4;
  localparam logic [7:0] PAGE_CTRL_RESET = 8'h01;
  localparam logic [7:0] ACTIVE_PAGE_RESET = 8'h00;
  localparam logic [7:0] STACK_VIEW_RESET = 8'h00;
  localparam int STACK_LEVELS = 5;

  // --------------------------------------------------------------------
  // Bit-addressable low nibbles and bit operations
  // --------------------------------------------------------------------
  localparam logic [3:0] BITADDR_NIB_A = 4'h0;
  localparam logic [3:0] BITADDR_NIB_B = 4'h8;

  typedef enum logic [1:0] {
    SFRPG_BIT_NONE,
    SFRPG_BIT_SET,
    SFRPG_BIT_CLEAR,
    SFRPG_BIT_TEST
  } sfrpg_bitop_t;

endpackage : sfrpg_pkg

// [design/sfrpg_decode.sv]
module sfrpg_decode (
  input wire logic [7:0] addr_in,
  input wire logic [7:0] page_in,
  output logic sel_page_out,
  output logic sel_ctrl_out,
  output logic sel_view_out,
  output logic split_out,
  output logic bitaddr_out
);

  // --------------------------------------------------------------------
  // Addresses holding a distinct register on page 0 and on page F
  // --------------------------------------------------------------------
  function automatic logic is_split(input logic [7:0] a);
    unique case (a)
      8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97,
      8'hAB, 8'hAC, 8'hAD, 8'hAE,
      8'hB9,
      8'hC0, 8'hC1, 8'hC2,
      8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
      8'hD2, 8'hD3, 8'hD7,
      8'hE7: is_split = 1'b1;
      default: is_split = 1'b0;
    endcase
  endfunction : is_split

  function automatic logic is_bitaddr(input logic [7:0] a);
    is_bitaddr = (a[3:0] == sfrpg_pkg::BITADDR_NIB_A) ||
                 (a[3:0] == sfrpg_pkg::BITADDR_NIB_B);
  endfunction : is_bitaddr

  logic on_page_f;

  always_comb begin
    on_page_f = (page_in == sfrpg_pkg::PAGE_F);
    sel_page_out = (addr_in == sfrpg_pkg::ADDR_ACTIVE_PAGE);
    sel_ctrl_out = (addr_in == sfrpg_pkg::ADDR_PAGE_CTRL);
    sel_view_out = on_page_f && (addr_in == sfrpg_pkg::ADDR_STACK_VIEW);
    split_out = is_split(addr_in);
    bitaddr_out = is_bitaddr(addr_in);
  end

endmodule : sfrpg_decode

// [design/sfrpg_stack.sv]
// Notes on behaviour
// - A read of the stack view returns the stack level picked by the level select field.
// - The stack view is an 8-bit read-only window, zero after reset, and writes never change the stack.
// - The stack view answers at address D3 only while the active page is F.
// - Addresses with low nibble 0 or 8 are bit-addressable and take bit set, clear and test.
// - Addresses decode the same on page 0 and page F except where each page has its own register.
// - The active page register steers the split addresses and the stack view at D3, and reads back the page in use.
// - Level select 0 shows the active page, 1 to 4 the lower levels, and 5 to 7 are invalid.
// - The stack pushes only on interrupt entry and pops only on return_from_interrupt, when auto paging is on.
// - With auto paging on (reset 1) entry pushes the active page and loads the interrupt page.
module sfrpg_stack (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_RD_IN,
  input wire logic SFR_WR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  input wire logic [1:0] SFR_BIT_OP_IN,
  input wire logic [2:0] SFR_BIT_SEL_IN,
  input wire logic IRQ_ENTRY_IN,
  input wire logic [7:0] IRQ_PAGE_IN,
  input wire logic RETURN_FROM_INTERRUPT_IN,
  output logic [7:0] SFR_RDATA_OUT,
  output logic SFR_RACK_OUT,
  output logic EXT_SEL_OUT,
  output logic EXT_WR_OUT,
  output logic [7:0] EXT_ADDR_OUT,
  output logic [7:0] EXT_WDATA_OUT,
  output logic EXT_PAGE_F_OUT,
  output logic EXT_BITADDR_OUT,
  output logic [1:0] EXT_BIT_OP_OUT,
  output logic [2:0] EXT_BIT_SEL_OUT,
  output logic [7:0] ACTIVE_PAGE_OUT,
  output logic AUTO_PAGING_OUT
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [sfrpg_pkg::STACK_LEVELS-1:0][7:0] stack_q;
  logic [2:0] stack_level_select_q;
  logic auto_paging_enable_q;
  logic [7:0] rdata_q;
  logic rack_q;
  logic sel_page, sel_ctrl, sel_view, split, bitaddr;
  logic own_sel, push, pop, page_wr, ctrl_wr;
  logic [7:0] view_val;
  logic [7:0] ctrl_val;

  sfrpg_decode u_decode (
    .addr_in(SFR_ADDR_IN),
    .page_in(stack_q[0]),
    .sel_page_out(sel_page),
    .sel_ctrl_out(sel_ctrl),
    .sel_view_out(sel_view),
    .split_out(split),
    .bitaddr_out(bitaddr)
  );

  // --------------------------------------------------------------------
  // Access qualification
  // --------------------------------------------------------------------
  always_comb begin
    own_sel = sel_page || sel_ctrl || sel_view;
    push = IRQ_ENTRY_IN && auto_paging_enable_q;
    pop = RETURN_FROM_INTERRUPT_IN && auto_paging_enable_q && !push;
    page_wr = SFR_WR_IN && sel_page;
    ctrl_wr = SFR_WR_IN && sel_ctrl;
    view_val = sfrpg_pkg::STACK_VIEW_RESET;
    if (stack_level_select_q <= sfrpg_pkg::IDX_LAST_LEVEL) begin
      view_val = stack_q[stack_level_select_q];
    end
    ctrl_val = 8'h00;
    ctrl_val[sfrpg_pkg::IDX_MSB:sfrpg_pkg::IDX_LSB] = stack_level_select_q;
    ctrl_val[sfrpg_pkg::AUTO_EN_BIT] = auto_paging_enable_q;
  end

  // --------------------------------------------------------------------
  // Page stack; level 0 is the active page
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      stack_q <= '0;
    end else if (push) begin
      stack_q <= {stack_q[sfrpg_pkg::STACK_LEVELS-2:0], IRQ_PAGE_IN};
    end else if (pop) begin
      stack_q <= {8'h00, stack_q[sfrpg_pkg::STACK_LEVELS-1:1]};
    end else if (page_wr) begin
      stack_q[0] <= SFR_WDATA_IN;
    end
  end

  // --------------------------------------------------------------------
  // Page control register
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      stack_level_select_q <=
        sfrpg_pkg::PAGE_CTRL_RESET[sfrpg_pkg::IDX_MSB:sfrpg_pkg::IDX_LSB];
      auto_paging_enable_q <=
        sfrpg_pkg::PAGE_CTRL_RESET[sfrpg_pkg::AUTO_EN_BIT];
    end else if (ctrl_wr) begin
      stack_level_select_q <=
        SFR_WDATA_IN[sfrpg_pkg::IDX_MSB:sfrpg_pkg::IDX_LSB];
      auto_paging_enable_q <= SFR_WDATA_IN[sfrpg_pkg::AUTO_EN_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Read answer for own registers
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= 8'h00;
      rack_q <= 1'b0;
    end else begin
      rack_q <= SFR_RD_IN && own_sel;
      if (SFR_RD_IN && sel_view) begin
        rdata_q <= view_val;
      end else if (SFR_RD_IN && sel_page) begin
        rdata_q <= stack_q[0];
      end else if (SFR_RD_IN && sel_ctrl) begin
        rdata_q <= ctrl_val;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------------
  // Forwarding of all other addresses to the peripheral space
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      EXT_SEL_OUT <= 1'b0;
      EXT_WR_OUT <= 1'b0;
      EXT_ADDR_OUT <= 8'h00;
      EXT_WDATA_OUT <= 8'h00;
      EXT_PAGE_F_OUT <= 1'b0;
      EXT_BITADDR_OUT <= 1'b0;
      EXT_BIT_OP_OUT <= sfrpg_pkg::SFRPG_BIT_NONE;
      EXT_BIT_SEL_OUT <= 3'h0;
    end else begin
      EXT_SEL_OUT <= (SFR_RD_IN || SFR_WR_IN) && !own_sel;
      EXT_WR_OUT <= SFR_WR_IN && !own_sel;
      EXT_ADDR_OUT <= SFR_ADDR_IN;
      EXT_WDATA_OUT <= SFR_WDATA_IN;
      EXT_PAGE_F_OUT <= split && (stack_q[0] == sfrpg_pkg::PAGE_F);
      EXT_BITADDR_OUT <= bitaddr;
      EXT_BIT_OP_OUT <= bitaddr && !own_sel ? SFR_BIT_OP_IN
                                            : sfrpg_pkg::SFRPG_BIT_NONE;
      EXT_BIT_SEL_OUT <= SFR_BIT_SEL_IN;
    end
  end

  always_comb begin
    SFR_RDATA_OUT = rdata_q;
    SFR_RACK_OUT = rack_q;
    ACTIVE_PAGE_OUT = stack_q[0];
    AUTO_PAGING_OUT = auto_paging_enable_q;
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  chk_view_level_read: assert property (
    (SFR_RD_IN && sel_view && stack_level_select_q == 3'h0)
      |=> SFR_RDATA_OUT == $past(ACTIVE_PAGE_OUT) && SFR_RACK_OUT)
    else $error("Stack view level 0 does not match active page");

  chk_view_reset_zero: assert property (
    disable iff (1'b0) !RST_N_IN |=> stack_q == '0 && rdata_q == 8'h00)
    else $error("Page stack not cleared by reset");

  chk_view_write_kept: assert property (
    (SFR_WR_IN && sel_view && !IRQ_ENTRY_IN && !RETURN_FROM_INTERRUPT_IN)
      |=> $stable(stack_q) && !EXT_SEL_OUT)
    else $error("Write to stack view changed the stack");

  chk_view_page_gate: assert property (
    (SFR_RD_IN && SFR_ADDR_IN == sfrpg_pkg::ADDR_STACK_VIEW &&
     ACTIVE_PAGE_OUT != sfrpg_pkg::PAGE_F) |=> !SFR_RACK_OUT && EXT_SEL_OUT)
    else $error("Stack view answered off page F");

  chk_bit_addr_flag: assert property (
    (SFR_RD_IN && (SFR_ADDR_IN[3:0] == 4'h0 || SFR_ADDR_IN[3:0] == 4'h8))
      |=> EXT_BITADDR_OUT)
    else $error("Bit-addressable location not flagged");

  chk_shared_decode: assert property (
    (SFR_RD_IN && SFR_ADDR_IN == 8'hE0) |=> EXT_SEL_OUT && !EXT_PAGE_F_OUT)
    else $error("Shared address decoded as page F only");

  chk_page_write_read: assert property (
    (SFR_WR_IN && sel_page && !IRQ_ENTRY_IN && !RETURN_FROM_INTERRUPT_IN)
      ##1 (SFR_RD_IN && sel_page) |=> SFR_RDATA_OUT == $past(SFR_WDATA_IN, 2))
    else $error("Active page does not read back written value");

  chk_page_gap_read: assert property (
    (SFR_WR_IN && sel_page && !IRQ_ENTRY_IN && !RETURN_FROM_INTERRUPT_IN)
      ##1 (!SFR_WR_IN && !IRQ_ENTRY_IN && !RETURN_FROM_INTERRUPT_IN)
      ##1 (SFR_RD_IN && sel_page) |=> SFR_RDATA_OUT == $past(SFR_WDATA_IN, 3))
    else $error("Active page lost written value over an idle cycle");

  chk_invalid_index: assert property (
    (SFR_RD_IN && sel_view && stack_level_select_q > 3'h4 &&
     !IRQ_ENTRY_IN && !RETURN_FROM_INTERRUPT_IN)
      |=> SFR_RDATA_OUT == 8'h00 ##0 $stable(ACTIVE_PAGE_OUT))
    else $error("Invalid level select did not read zero");

  chk_stack_quiet: assert property (
    (!IRQ_ENTRY_IN && !RETURN_FROM_INTERRUPT_IN && !page_wr)
      |=> $stable(stack_q))
    else $error("Page stack moved without push or pop");

  chk_entry_push: assert property (
    (IRQ_ENTRY_IN && AUTO_PAGING_OUT) |=> ACTIVE_PAGE_OUT == $past(IRQ_PAGE_IN)
      && stack_q[1] == $past(stack_q[0]) && stack_q[4] == $past(stack_q[3]))
    else $error("Interrupt entry push wrong");

  chk_disabled_hold: assert property (
    (!AUTO_PAGING_OUT && !page_wr) |=> $stable(stack_q))
    else $error("Stack moved with auto paging off");

  cov_push_pop: cover property (push ##[1:20] pop);
  cov_view_bottom: cover property (
    SFR_RD_IN && sel_view && stack_level_select_q == 3'h4);
  cov_split_page_f: cover property (
    (SFR_RD_IN || SFR_WR_IN) && split && ACTIVE_PAGE_OUT == 8'h0F);

endmodule : sfrpg_stack

// [test/sfrpg_core_model.sv]
module sfrpg_core_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic rd_out,
  output logic wr_out,
  output logic [7:0] wdata_out,
  output logic [1:0] bit_op_out,
  output logic [2:0] bit_sel_out,
  output logic irq_out,
  output logic [7:0] irq_page_out,
  output logic ret_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {addr_out, rd_out, wr_out, wdata_out, bit_op_out} = '0;
    {bit_sel_out, irq_out, irq_page_out, ret_out} = '0;
  end

  // ------------------------------------------------------------
  // One access, held for exactly one taking edge
  // ------------------------------------------------------------
  task automatic drive(input logic rd, wr, input logic [7:0] a, wd,
                       input logic [1:0] op, input logic [2:0] bs,
                       input logic irq, input logic [7:0] ip,
                       input logic ret);
    @(posedge clk_in);
    #1;
    {rd_out, wr_out, addr_out, wdata_out} = {rd, wr, a, wd};
    {bit_op_out, bit_sel_out, irq_out, irq_page_out} = {op, bs, irq, ip};
    ret_out = ret;
    @(posedge clk_in);
    #1;
    {rd_out, wr_out, irq_out, ret_out} = '0;
    // Released address, data and interrupt page lines show the inverse of the last value
    addr_out = ~a;
    wdata_out = ~wd;
    irq_page_out = ~ip;
  endtask : drive
endmodule : sfrpg_core_model

// [test/sfr_page_stack_readout_tb.sv]
module sfr_page_stack_readout_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] a_w, wd_w, ip_w, rdata, act_pg, ext_a, ext_wd;
  logic [1:0] op_w, ext_op;
  logic [2:0] bs_w, ext_bs;
  logic rd_w, wr_w, irq_w, ret_w, rack, esel, ewr, epf, ebit, auto;
  logic [7:0] lv[5] = '{default: 8'h00};
  logic [2:0] idx = 3'h0;
  logic en = 1'b1;
  logic rd_rnd;
  int errors = 0;
  int n_checks = 0;
  int seed = 32'hC505;

  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  sfrpg_core_model sfrpg_core_model_i (.clk_in(clk_in), .addr_out(a_w),
    .rd_out(rd_w), .wr_out(wr_w), .wdata_out(wd_w), .bit_op_out(op_w),
    .bit_sel_out(bs_w), .irq_out(irq_w), .irq_page_out(ip_w),
    .ret_out(ret_w));

  sfrpg_stack sfrpg_stack_i (.CLK_IN(clk_in), .RST_N_IN(rst_n_in),
    .SFR_ADDR_IN(a_w), .SFR_RD_IN(rd_w), .SFR_WR_IN(wr_w),
    .SFR_WDATA_IN(wd_w), .SFR_BIT_OP_IN(op_w), .SFR_BIT_SEL_IN(bs_w),
    .IRQ_ENTRY_IN(irq_w), .IRQ_PAGE_IN(ip_w),
    .RETURN_FROM_INTERRUPT_IN(ret_w), .SFR_RDATA_OUT(rdata),
    .SFR_RACK_OUT(rack), .EXT_SEL_OUT(esel), .EXT_WR_OUT(ewr),
    .EXT_ADDR_OUT(ext_a), .EXT_WDATA_OUT(ext_wd), .EXT_PAGE_F_OUT(epf),
    .EXT_BITADDR_OUT(ebit), .EXT_BIT_OP_OUT(ext_op),
    .EXT_BIT_SEL_OUT(ext_bs), .ACTIVE_PAGE_OUT(act_pg),
    .AUTO_PAGING_OUT(auto));

  task automatic chk(input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  function automatic logic split(input logic [7:0] a);
    return a inside {[8'h91:8'h97], [8'hAB:8'hAE], 8'hB9, [8'hC0:8'hC2],
      8'hC8, [8'hCA:8'hCD], 8'hD2, 8'hD3, 8'hD7, 8'hE7};
  endfunction : split

  // ------------------------------------------------------------
  // Access with reference model and comparison
  // ------------------------------------------------------------
  task automatic acc(input logic rd, wr, input logic [7:0] a, wd,
                     input logic [1:0] op, input logic irq, ret,
                     input logic [7:0] ip);
    logic own;
    logic [7:0] ev;
    logic [2:0] bs;
    own = a == 8'hA7 || a == 8'hCF || (a == 8'hD3 && lv[0] == 8'h0F);
    ev = a == 8'hA7 ? lv[0] : a == 8'hCF ? {1'b0, idx, 3'h0, en} :
      idx < 3'h5 ? lv[idx] : 8'h00;
    bs = 3'($random(seed));
    sfrpg_core_model_i.drive(rd, wr, a, wd, op, bs, irq, ip, ret);
    chk(rdata, (rd && own) ? ev : 8'h00);
    chk(8'(rack), 8'(rd && own));
    chk(8'(esel), 8'((rd || wr) && !own));
    chk(8'(epf), 8'(split(a) && lv[0] == 8'h0F));
    chk(8'(ebit), 8'(a[2:0] == 3'h0));
    chk(8'(ewr), 8'(wr && !own));
    chk(ext_a, a);
    chk(ext_wd, wd);
    chk(8'(ext_bs), 8'(bs));
    if (rd || wr)
      chk(8'(ext_op), (a[2:0] == 3'h0 && !own) ? 8'(op) : 8'h00);
    if (irq && en) begin
      for (int i = 4; i > 0; i--)
        lv[i] = lv[i - 1];
      lv[0] = ip;
    end else if (ret && en) begin
      for (int i = 0; i < 4; i++)
        lv[i] = lv[i + 1];
      lv[4] = 8'h00;
    end else if (wr && a == 8'hA7) begin
      lv[0] = wd;
    end
    if (wr && a == 8'hCF) begin
      idx = wd[6:4];
      en = wd[0];
    end
    chk(act_pg, lv[0]);
    chk(8'(auto), 8'(en));
  endtask : acc

  initial begin
    #200000;
    errors++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    acc(1, 0, 8'hCF, 8'h00, 2'h0, 0, 0, 8'h00);
    acc(1, 0, 8'hD3, 8'h00, 2'h0, 0, 0, 8'h00);
    for (int i = 0; i < 7; i++)
      acc(0, 0, 8'h00, 8'h00, 2'h0, 1, 0, 8'($random(seed)));
    acc(0, 1, 8'hA7, 8'h0F, 2'h0, 0, 0, 8'h00);
    acc(1, 0, 8'hA7, 8'h00, 2'h0, 0, 0, 8'h00);
    acc(1, 0, 8'hE0, 8'h00, 2'h1, 0, 0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      acc(0, 1, 8'hCF, {1'b0, 3'(i), 4'h1}, 2'h0, 0, 0, 8'h00);
      acc(1, 0, 8'hD3, 8'h00, 2'h1, 0, 0, 8'h00);
      acc(0, 1, 8'hD3, 8'($random(seed)), 2'h2, 0, 0, 8'h00);
      acc(1, 0, 8'hD3, 8'h00, 2'h0, 0, 0, 8'h00);
    end
    acc(0, 0, 8'h00, 8'h00, 2'h0, 1, 1, 8'h0F);
    for (int i = 0; i < 6; i++)
      acc(1, 0, 8'hB9, 8'h00, 2'h3, 0, 1, 8'h00);
    for (int i = 0; i < 40; i++) begin
      rd_rnd = 1'($random(seed));
      acc(rd_rnd, !rd_rnd, 8'($random(seed)), 8'($random(seed)),
        2'($random(seed)), 1'($random(seed)), 1'($random(seed)),
        8'($random(seed)));
    end
    acc(0, 1, 8'hCF, 8'h00, 2'h0, 0, 0, 8'h00);
    acc(0, 0, 8'h00, 8'h00, 2'h0, 1, 0, 8'h5A);
    acc(0, 0, 8'h00, 8'h00, 2'h0, 0, 1, 8'h00);
    give_verdict();
  end
endmodule : sfr_page_stack_readout_tb
